// File: shared/fsktg_pkg.sv
// constants, types and helpers shared by the trip/guard receiver logic
// assumes a 20 mhz pclk and apb register access
package fsktg_pkg;

  // ==========================================================
  // timebase
  localparam int CLK_FREQ_MHZ = 20;
  localparam int TICK_PERIOD_US = 1000;
  localparam int TICK_CYCLES = TICK_PERIOD_US * CLK_FREQ_MHZ;

  // ==========================================================
  // millisecond figures
  localparam int TW = 11;
  typedef logic [TW-1:0] fsktg_ms_t;
  localparam fsktg_ms_t GBT_GUARD_MS = 11'h078;
  localparam fsktg_ms_t TAG_WIN_MS = 11'h078;
  localparam fsktg_ms_t OVR_TRIP_MS = 11'h3E8;
  localparam fsktg_ms_t OVR_RESET_MS = 11'h0C8;
  localparam fsktg_ms_t PRE_MAX_MS = 11'h01E;
  localparam fsktg_ms_t HOLD_MAX_MS = 11'h064;
  localparam fsktg_ms_t UBW_MAX_MS = 11'h1F4;
  localparam fsktg_ms_t UBD_MAX_MS = 11'h064;

  // ==========================================================
  // register map
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_PRE = 8'h04;
  localparam logic [7:0] OFF_THOLD = 8'h08;
  localparam logic [7:0] OFF_GHOLD = 8'h0C;
  localparam logic [7:0] OFF_UBWIN = 8'h10;
  localparam logic [7:0] OFF_UBDLY = 8'h14;
  localparam logic [7:0] OFF_STAT = 8'h18;
  localparam int CTRL_VAR_LSB = 0;
  localparam int CTRL_GBT_LSB = 2;
  localparam logic [1:0] VAR_2F_DIRECT = 2'h0;
  localparam logic [1:0] VAR_2F_UNBLOCK = 2'h1;
  localparam logic [1:0] VAR_3F = 2'h2;
  localparam logic [1:0] VAR_4F = 2'h3;
  localparam logic [1:0] GBT_OFF = 2'h0;
  localparam logic [1:0] GBT_ON = 2'h1;
  localparam logic [1:0] GBT_OVR = 2'h2;
  localparam logic [3:0] CTRL_RST = 4'h4;
  localparam fsktg_ms_t SET_RST = 11'h000;

  // ==========================================================
  // helpers
  function automatic fsktg_ms_t fsktg_clamp(input logic [31:0] v,
                                            input fsktg_ms_t lim);
    fsktg_clamp = (v > {21'h0, lim}) ? lim : v[TW-1:0];
  endfunction : fsktg_clamp

  // continuous-condition timer: clears at once, counts on tick
  function automatic fsktg_ms_t fsktg_bump(input fsktg_ms_t c,
                                           input logic cond,
                                           input logic tick,
                                           input fsktg_ms_t lim);
    if (!cond)
      fsktg_bump = '0;
    else if (tick && c < lim)
      fsktg_bump = c + 11'h001;
    else
      fsktg_bump = c;
  endfunction : fsktg_bump

endpackage : fsktg_pkg

// File: verilog/fsktg_chan.sv
// one guard/trip logic set: guard before trip, trip after guard,
// pre-trip, override and unblock timers
// assumes synchronised inputs and a one-cycle ms tick from the top
`timescale 1ns/1ns
module fsktg_chan (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ms_tick,
  input wire logic guard_in,
  input wire logic trip_in,
  input wire logic low_in,
  input wire logic ub_allow,
  input wire logic [1:0] gbt_mode,
  input wire fsktg_pkg::fsktg_ms_t pre_trip,
  input wire fsktg_pkg::fsktg_ms_t ub_win,
  input wire fsktg_pkg::fsktg_ms_t ub_dly,
  output logic trip_raw,
  output logic guard_raw,
  output logic low_out,
  output logic locked_out,
  output logic override_on
);
  import fsktg_pkg::*;

  fsktg_ms_t g_cnt_q;
  fsktg_ms_t t_cnt_q;
  fsktg_ms_t n_cnt_q;
  fsktg_ms_t d_cnt_q;
  fsktg_ms_t w_cnt_q;
  logic lock_q;
  logic ovr_q;
  logic loc;
  logic loc_dly;
  logic ub_on;
  logic ub_active;
  logic permit;

  // ==========================================================
  // qualifiers
  assign loc = low_in && !guard_in;
  // no delay stage where the unblock path is absent
  assign loc_dly = loc && (!ub_allow || d_cnt_q >= ub_dly);
  assign ub_on = ub_allow && (ub_win != SET_RST);
  assign ub_active = ub_on && loc_dly && (w_cnt_q < ub_win);
  assign permit = (gbt_mode == GBT_OFF) || !lock_q || ovr_q;

  // ==========================================================
  // timers, all on the shared ms tick
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      g_cnt_q <= '0;
      t_cnt_q <= '0;
      n_cnt_q <= '0;
      d_cnt_q <= '0;
      w_cnt_q <= '0;
    end
    else
    begin
      g_cnt_q <= fsktg_bump(g_cnt_q, guard_in, ms_tick, OVR_RESET_MS);
      t_cnt_q <= fsktg_bump(t_cnt_q, trip_in, ms_tick,
                            OVR_TRIP_MS + 11'h001);
      n_cnt_q <= fsktg_bump(n_cnt_q, !guard_in && !trip_in, ms_tick,
                            TAG_WIN_MS);
      d_cnt_q <= fsktg_bump(d_cnt_q, loc, ms_tick, UBD_MAX_MS);
      w_cnt_q <= fsktg_bump(w_cnt_q, loc_dly && ub_on, ms_tick,
                            UBW_MAX_MS);
    end
  end

  // ==========================================================
  // lockout: starts locked so guard must be seen first
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      lock_q <= 1'b1;
    else if (!loc && n_cnt_q >= TAG_WIN_MS)
      lock_q <= 1'b1;
    else if (ub_on && loc_dly && w_cnt_q >= ub_win)
      lock_q <= 1'b1;
    else if (g_cnt_q >= GBT_GUARD_MS)
      lock_q <= 1'b0;
  end

  // ==========================================================
  // override for open remote breaker
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ovr_q <= 1'b0;
    else if (gbt_mode != GBT_OVR)
      ovr_q <= 1'b0;
    else if (t_cnt_q > OVR_TRIP_MS)
      ovr_q <= 1'b1;
    else if (g_cnt_q >= OVR_RESET_MS)
      ovr_q <= 1'b0;
  end

  // ==========================================================
  // unstretched results for the output stage
  assign trip_raw = (trip_in && permit && t_cnt_q >= pre_trip)
                    || ub_active;
  assign guard_raw = guard_in;
  assign low_out = loc_dly;
  assign locked_out = lock_q;
  assign override_on = ovr_q;

endmodule : fsktg_chan

// File: verilog/fsktg_top.sv
// trip/guard receiver logic for fsk teleprotection, two logic sets
// assumes async detector levels on pins and an apb master on pclk
//
// Overview of operation
// - three-tone mode runs separate direct trip set
// - each path's trip drops only its guard
// - four tones feed two independent logic sets
// - command one trip keeps command two guard
// - trip waits for pre-trip delay, 0-30 ms
// - trip output stretched by trip hold time
// - guard output stretched by guard hold time
// - loss of channel trips for unblock window
// - loss means low level and no guard
// - no unblock timers in two-tone direct mode
// - trip refused until 120 ms guard seen
// - override after 1000 ms trip waives guard
// - unblock delay delays window and low output
// - no trip 120 ms after guard loss locks
// - window expiry locks until 120 ms guard
// - hold timers act on outputs only
// - override cleared 200 ms after guard returns
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
module fsktg_top #(
  parameter int CYC_PER_MS = fsktg_pkg::TICK_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic guard_tone,
  input wire logic cmd_one_tone,
  input wire logic cmd_two_tone,
  input wire logic combined_cmd_tone,
  input wire logic rx_level_low,
  output logic trip_a,
  output logic guard_a,
  output logic trip_b,
  output logic guard_b,
  output logic low_level_a,
  output logic low_level_b
);
  import fsktg_pkg::*;

  localparam int NIN = 5;
  localparam int NOUT = 4;

  logic [NIN-1:0] sync1_q;
  logic [NIN-1:0] sync2_q;
  logic [31:0] tick_cnt_q;
  logic ms_tick;
  logic [3:0] ctrl_q;
  fsktg_ms_t pre_q;
  fsktg_ms_t thold_q;
  fsktg_ms_t ghold_q;
  fsktg_ms_t ubwin_q;
  fsktg_ms_t ubdly_q;
  logic [1:0] variant;
  logic [1:0] gbt_mode;
  logic g_tone;
  logic one_tone;
  logic two_tone;
  logic both_tone;
  logic low_lvl;
  logic a_guard;
  logic a_trip;
  logic a_ub;
  logic b_guard;
  logic b_trip;
  logic b_ub;
  logic b_used;
  logic a_trip_raw;
  logic a_guard_raw;
  logic b_trip_raw;
  logic b_guard_raw;
  logic a_low;
  logic b_low;
  logic a_lock;
  logic b_lock;
  logic a_ovr;
  logic b_ovr;
  logic [NOUT-1:0] raw_v;
  logic [NOUT-1:0] out_q;
  fsktg_ms_t hold_cnt_q [NOUT];
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic [31:0] rd_val;

  // ==========================================================
  // pin synchronisers, first stage read only by the second
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
    end
    else
    begin
      sync1_q <= {rx_level_low, combined_cmd_tone, cmd_two_tone,
                  cmd_one_tone, guard_tone};
      sync2_q <= sync1_q;
    end
  end

  assign g_tone = sync2_q[0];
  assign one_tone = sync2_q[1];
  assign two_tone = sync2_q[2];
  assign both_tone = sync2_q[3];
  assign low_lvl = sync2_q[4];

  // ==========================================================
  // millisecond timebase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tick_cnt_q <= '0;
    else if (tick_cnt_q >= 32'(CYC_PER_MS - 1))
      tick_cnt_q <= '0;
    else
      tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
  end

  assign ms_tick = (tick_cnt_q >= 32'(CYC_PER_MS - 1));

  // ==========================================================
  // tone routing per variant
  // set a is the unblock path or command one, set b the direct
  // trip path or command two; a trip tone on one set replaces
  // the shared guard tone, so it counts as guard for the other
  assign variant = ctrl_q[CTRL_VAR_LSB +: 2];
  assign gbt_mode = ctrl_q[CTRL_GBT_LSB +: 2];

  always_comb
  begin
    a_guard = g_tone;
    a_trip = one_tone;
    a_ub = 1'b0;
    b_guard = 1'b0;
    b_trip = 1'b0;
    b_ub = 1'b0;
    b_used = 1'b0;
    unique case (variant)
      VAR_2F_DIRECT:
      begin
        a_ub = 1'b0;
      end
      VAR_2F_UNBLOCK:
      begin
        a_ub = 1'b1;
      end
      VAR_3F:
      begin
        a_ub = 1'b1;
        a_guard = g_tone || two_tone;
        b_guard = g_tone || one_tone;
        b_trip = two_tone;
        b_used = 1'b1;
      end
      VAR_4F:
      begin
        a_ub = 1'b1;
        b_ub = 1'b1;
        a_trip = one_tone || both_tone;
        b_trip = two_tone || both_tone;
        a_guard = g_tone || two_tone;
        b_guard = g_tone || one_tone;
        b_used = 1'b1;
      end
    endcase
  end

  // ==========================================================
  // logic sets
  fsktg_chan u_chan_a (
    .pclk(pclk),
    .presetn(presetn),
    .ms_tick(ms_tick),
    .guard_in(a_guard),
    .trip_in(a_trip),
    .low_in(low_lvl),
    .ub_allow(a_ub),
    .gbt_mode(gbt_mode),
    .pre_trip(pre_q),
    .ub_win(ubwin_q),
    .ub_dly(ubdly_q),
    .trip_raw(a_trip_raw),
    .guard_raw(a_guard_raw),
    .low_out(a_low),
    .locked_out(a_lock),
    .override_on(a_ovr)
  );

  // second copy: its own guard before trip, lockout and override
  fsktg_chan u_chan_b (
    .pclk(pclk),
    .presetn(presetn),
    .ms_tick(ms_tick),
    .guard_in(b_guard),
    .trip_in(b_trip),
    .low_in(low_lvl && b_used),
    .ub_allow(b_ub),
    .gbt_mode(gbt_mode),
    .pre_trip(pre_q),
    .ub_win(ubwin_q),
    .ub_dly(ubdly_q),
    .trip_raw(b_trip_raw),
    .guard_raw(b_guard_raw),
    .low_out(b_low),
    .locked_out(b_lock),
    .override_on(b_ovr)
  );

  // ==========================================================
  // output stretchers, never fed back into the logic sets
  assign raw_v = {b_guard_raw && b_used, b_trip_raw,
                  a_guard_raw, a_trip_raw};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      out_q <= '0;
      for (int i = 0; i < NOUT; i++)
        hold_cnt_q[i] <= '0;
    end
    else
    begin
      for (int i = 0; i < NOUT; i++)
      begin
        if (raw_v[i])
          hold_cnt_q[i] <= (i % 2 == 0) ? thold_q : ghold_q;
        else if (ms_tick && hold_cnt_q[i] != SET_RST)
          hold_cnt_q[i] <= hold_cnt_q[i] - 11'h001;
        out_q[i] <= raw_v[i] || (hold_cnt_q[i] != SET_RST);
      end
    end
  end

  assign trip_a = out_q[0];
  assign guard_a = out_q[1];
  assign trip_b = out_q[2];
  assign guard_b = out_q[3];
  assign low_level_a = a_low;
  assign low_level_b = b_low;

  // ==========================================================
  // apb slave, zero wait states
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign addr_ok = (paddr == OFF_CTRL) || (paddr == OFF_PRE) ||
                   (paddr == OFF_THOLD) || (paddr == OFF_GHOLD) ||
                   (paddr == OFF_UBWIN) || (paddr == OFF_UBDLY) ||
                   (paddr == OFF_STAT);
  assign pslverr = psel && penable && !addr_ok;

  // settings above range are clamped rather than refused
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= CTRL_RST;
      pre_q <= SET_RST;
      thold_q <= SET_RST;
      ghold_q <= SET_RST;
      ubwin_q <= SET_RST;
      ubdly_q <= SET_RST;
    end
    else if (wr_en)
    begin
      unique case (paddr)
        OFF_CTRL: ctrl_q <= pwdata[3:0];
        OFF_PRE: pre_q <= fsktg_clamp(pwdata, PRE_MAX_MS);
        OFF_THOLD: thold_q <= fsktg_clamp(pwdata, HOLD_MAX_MS);
        OFF_GHOLD: ghold_q <= fsktg_clamp(pwdata, HOLD_MAX_MS);
        OFF_UBWIN: ubwin_q <= fsktg_clamp(pwdata, UBW_MAX_MS);
        OFF_UBDLY: ubdly_q <= fsktg_clamp(pwdata, UBD_MAX_MS);
        default: ctrl_q <= ctrl_q;
      endcase
    end
  end

  always_comb
  begin
    rd_val = '0;
    unique case (paddr)
      OFF_CTRL: rd_val = {28'h000_0000, ctrl_q};
      OFF_PRE: rd_val = {21'h00_0000, pre_q};
      OFF_THOLD: rd_val = {21'h00_0000, thold_q};
      OFF_GHOLD: rd_val = {21'h00_0000, ghold_q};
      OFF_UBWIN: rd_val = {21'h00_0000, ubwin_q};
      OFF_UBDLY: rd_val = {21'h00_0000, ubdly_q};
      OFF_STAT: rd_val = {22'h00_0000, b_ovr, a_ovr, b_lock, a_lock,
                          b_low, a_low, out_q};
      default: rd_val = '0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= '0;
    else if (psel && !penable && !pwrite)
      prdata <= rd_val;
  end

endmodule : fsktg_top

// File: tb/fsktg_det_model.sv
// frequency detector model: turns bench tone requests into pin levels
// assumes the bench changes want just after a rising edge
`timescale 1ns/1ns
module fsktg_det_model (
  input wire logic pclk,
  input wire logic slow,
  input wire logic [4:0] want,
  output logic [4:0] tones
);
  // ==========================================================
  // detector latency, prompt or one cycle slower
  logic [4:0] stage_q;
  always_ff @(posedge pclk)
  begin
    stage_q <= want;
    tones <= slow ? stage_q : want;
  end
endmodule : fsktg_det_model

// File: tb/fsktg_props.sv
// port checker for the trip/guard receiver top
// assumes the register map of fsktg_pkg; bound below
`timescale 1ns/1ns
module fsktg_props
  import fsktg_pkg::*;
#(
  parameter int CYC_PER_MS = fsktg_pkg::TICK_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic cmd_one_tone,
  input wire logic combined_cmd_tone,
  input wire logic rx_level_low,
  input wire logic trip_a,
  input wire logic low_level_a
);
  // ==========================================================
  // shadow of the control word
  logic [3:0] ctrl_q;
  wire acc = psel & penable;
  wire far = paddr > OFF_STAT;
  wire cause = cmd_one_tone | combined_cmd_tone | rx_level_low;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      ctrl_q <= CTRL_RST;
    else if (acc && pwrite && paddr == OFF_CTRL)
      ctrl_q <= pwdata[3:0];
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ==========================================================
  // bus and output relations
  a_ready_high: assert property (pready)
    else $error("pready low");
  a_err_idle: assert property (!acc |-> !pslverr)
    else $error("error outside access");
  a_err_far: assert property (acc && far |-> pslverr)
    else $error("no error on unmapped");
  a_err_near: assert property (acc && !far && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("error on mapped");
  a_rdata_hold: assert property (acc |=> $stable(prdata))
    else $error("read data moved in access");
  a_far_zero: assert property (acc && far && !pwrite |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_ctrl_read: assert property (acc && !pwrite && paddr == OFF_CTRL
    |-> prdata == {28'h000_0000, ctrl_q})
    else $error("control readback wrong");
  a_trip_cause: assert property ($rose(trip_a) |->
    $past(cause, 2) || $past(cause, 3) || $past(cause, 4))
    else $error("trip without cause");
  a_low_cause: assert property (low_level_a |->
    $past(rx_level_low, 1) || $past(rx_level_low, 2) ||
    $past(rx_level_low, 3))
    else $error("low output without low level");
  c_trip: cover property ($rose(trip_a));
  c_low: cover property ($rose(low_level_a));
  c_err: cover property (acc && pslverr);
endmodule : fsktg_props

bind fsktg_top fsktg_props #(.CYC_PER_MS(CYC_PER_MS)) u_fsktg_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .cmd_one_tone(cmd_one_tone),
  .combined_cmd_tone(combined_cmd_tone), .rx_level_low(rx_level_low),
  .trip_a(trip_a), .low_level_a(low_level_a)
);

// File: tb/test_fsktg_top.sv
// self-checking bench for the trip/guard receiver logic
// assumes detector model and checker compile first; 10 cycles per ms
`timescale 1ns/1ns
module test_fsktg_top;
  import fsktg_pkg::*;
  // ==========================================================
  // clock, reset and wiring
  localparam int MS = 10;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, last_err;
  logic slow = 1'b0;
  logic [4:0] want = 5'h00;
  logic [4:0] tones;
  logic trip_a, guard_a, trip_b, guard_b, low_a, low_b;
  logic [31:0] r, v;
  logic [7:0] offs [5] = '{OFF_PRE, OFF_THOLD, OFF_GHOLD, OFF_UBWIN,
                           OFF_UBDLY};
  int maxs [5] = '{30, 100, 100, 500, 100};
  int fail_count = 0;
  int checks = 0;
  int cycles = 0;
  int pre, dly;
  always #25 pclk = ~pclk;
  fsktg_det_model u_fsktg_det_model (.pclk(pclk), .slow(slow),
    .want(want), .tones(tones));
  fsktg_top #(.CYC_PER_MS(MS)) u_fsktg_top (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .guard_tone(tones[0]), .cmd_one_tone(tones[1]),
    .cmd_two_tone(tones[2]), .combined_cmd_tone(tones[3]),
    .rx_level_low(tones[4]), .trip_a(trip_a), .guard_a(guard_a),
    .trip_b(trip_b), .guard_b(guard_b), .low_level_a(low_a),
    .low_level_b(low_b));
  // ==========================================================
  // helpers
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  function automatic logic [31:0] lim(input logic [31:0] x, input int m);
    return (x > 32'(m)) ? 32'(m) : x;
  endfunction : lim
  // hold the whole request until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    r = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask : rd
  task automatic ms(input int n);
    repeat (n * MS) @(posedge pclk);
  endtask : ms
  task automatic setup(input logic [3:0] c, input int p, th, gh, ub, d);
    apb(1'b1, OFF_CTRL, {28'h000_0000, c});
    apb(1'b1, OFF_PRE, 32'(p));
    apb(1'b1, OFF_THOLD, 32'(th));
    apb(1'b1, OFF_GHOLD, 32'(gh));
    apb(1'b1, OFF_UBWIN, 32'(ub));
    apb(1'b1, OFF_UBDLY, 32'(d));
    pre = p;
    want <= 5'h01;
    ms(125);
  endtask : setup
  // one command per step, guard restored between
  task automatic cmds(input logic [3:0] c, input int n);
    logic [4:0] pat [3] = '{5'h02, 5'h04, 5'h08};
    logic [3:0] exp [3] = '{4'h9, 4'h6, 4'hC};
    setup(c, $urandom_range(8, 4), 0, 0, 0, 0);
    for (int i = 0; i < n; i++)
    begin
      want <= pat[i];
      ms(pre + 2);
      chk({trip_a, trip_b, guard_a, guard_b}, exp[i]);
      want <= 5'h01;
      ms(20);
    end
    $display("end of command test %h", c);
  endtask : cmds
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 60000)
    begin
      fail_count++;
      wrap_up();
    end
  end
  // ==========================================================
  // main sequence
  initial
  begin
    v = $urandom(42);
    slow <= 1'($urandom % 2);
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFF_CTRL);
    chk(r, 32'h0000_0004);
    rd(OFF_STAT);
    chk(r[6], 1'b1);
    for (int i = 0; i < 5; i++)
    begin
      v = $urandom_range(600);
      apb(1'b1, offs[i], v);
      rd(offs[i]);
      chk(r, lim(v, maxs[i]));
    end
    apb(1'b1, 8'h1C, 32'hFFFF_FFFF);
    rd(8'h1C);
    chk({r, last_err}, {32'h0000_0000, 1'b1});
    $display("end of register test");
    // no guard and no trip for 120 ms locks, then trip is refused
    setup(4'h4, $urandom_range(30, 20), 5, 6, 0, 0);
    want <= 5'h00;
    ms(125);
    rd(OFF_STAT);
    chk(r[6], 1'b1);
    want <= 5'h02;
    ms(40);
    chk(trip_a, 1'b0);
    want <= 5'h01;
    ms(60);
    want <= 5'h02;
    ms(40);
    chk(trip_a, 1'b0);
    want <= 5'h01;
    ms(125);
    rd(OFF_STAT);
    chk(r[6], 1'b0);
    want <= 5'h02;
    ms(4);
    chk(guard_a, 1'b1);
    ms(4);
    chk(guard_a, 1'b0);
    ms(pre - 10);
    chk(trip_a, 1'b0);
    ms(4);
    chk(trip_a, 1'b1);
    want <= 5'h00;
    ms(3);
    chk(trip_a, 1'b1);
    ms(4);
    chk(trip_a, 1'b0);
    $display("end of direct trip test");
    cmds(4'h6, 2);
    cmds(4'h7, 3);
    // unblock window on loss of channel
    dly = $urandom_range(20, 5);
    setup(4'h5, 5, 0, 0, 150, dly);
    want <= 5'h11;
    ms(30);
    chk({low_a, trip_a}, 2'h0);
    want <= 5'h10;
    ms(dly - 2);
    chk({low_a, trip_a}, 2'h0);
    ms(4);
    chk({low_b, low_a, trip_a}, 3'h3);
    ms(144);
    chk(trip_a, 1'b1);
    ms(6);
    chk(trip_a, 1'b0);
    want <= 5'h02;
    ms(40);
    chk(trip_a, 1'b0);
    $display("end of unblock test");
    // override after a long trip, then loss locks and trip returns
    setup(4'h9, 0, 0, 0, 10, 0);
    want <= 5'h02;
    ms(1010);
    want <= 5'h10;
    ms(30);
    rd(OFF_STAT);
    chk({r[8], r[6], trip_a}, 3'h6);
    want <= 5'h02;
    ms(5);
    chk(trip_a, 1'b1);
    want <= 5'h01;
    ms(190);
    rd(OFF_STAT);
    chk(r[8], 1'b1);
    ms(20);
    rd(OFF_STAT);
    chk(r[8], 1'b0);
    $display("end of override test");
    wrap_up();
  end
endmodule : test_fsktg_top
